/* src/tpmi_pkg.sv */
// register map, field layout, encodings and carriers of the timer pin and interrupt block
package tpmi_pkg;

  // register offsets (8-bit registers on a 4-bit address)
  localparam logic [3:0] ADR_ICR = 4'h0;
  localparam logic [3:0] ADR_TCR = 4'h1;
  localparam logic [3:0] ADR_OAC = 4'h2;
  localparam logic [3:0] ADR_OBC = 4'h3;
  localparam logic [3:0] ADR_IVR = 4'h4;
  localparam logic [3:0] ADR_MSK = 4'h5;
  localparam logic [3:0] ADR_FLG = 4'h6;
  localparam logic [3:0] ADR_STA = 4'h7;

  // reset values
  localparam logic [7:0] RST_ICR = 8'h00;
  localparam logic [7:0] RST_TCR = 8'h00;
  localparam logic [7:0] RST_OC = 8'h00;
  localparam logic [7:0] RST_IVR = 8'h00;
  localparam logic [7:0] RST_MSK = 8'h00;

  // input_control_reg fields
  localparam int ICR_FN_LSB = 0;
  localparam int ICR_EA_LSB = 4;
  localparam int ICR_EB_LSB = 6;
  // timer_control_reg fields
  localparam int TCR_DIR = 0;
  localparam int TCR_RM0 = 1;
  // output control fields
  localparam int OC_CMP0_LSB = 0;
  localparam int OC_CMP1_LSB = 2;
  localparam int OC_OVF_LSB = 4;
  localparam int OC_PRE = 6;
  localparam int OC_EV = 7;
  // vector, mask and flag fields
  localparam int IVR_LSB = 3;
  localparam int SRC_CMP0 = 0;
  localparam int SRC_CMP1 = 1;
  localparam int SRC_CAP0 = 2;
  localparam int SRC_CAP1 = 3;
  localparam int SRC_OVF = 4;
  localparam int MSK_GLB = 7;
  localparam int FLG_OVR0 = 5;
  localparam int FLG_OVR1 = 6;

  // fixed low vector bits per group
  localparam logic [2:0] VEC_CMP = 3'h6;
  localparam logic [2:0] VEC_CAP = 3'h4;
  localparam logic [2:0] VEC_OVF = 3'h0;

  // output actions
  localparam logic [1:0] ACT_NOP = 2'h0;
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_RST = 2'h2;
  localparam logic [1:0] ACT_TGL = 2'h3;

  // input pin function codes
  localparam logic [3:0] FN_NONE = 4'h0;
  localparam logic [3:0] FN_TRGB = 4'h1;
  localparam logic [3:0] FN_GATA = 4'h2;
  localparam logic [3:0] FN_GATRB = 4'h3;
  localparam logic [3:0] FN_CLKB = 4'h4;
  localparam logic [3:0] FN_TRGA = 4'h5;
  localparam logic [3:0] FN_GACB = 4'h6;
  localparam logic [3:0] FN_TRAB = 4'h7;
  localparam logic [3:0] FN_UPDN = 4'h8;
  localparam logic [3:0] FN_DACB = 4'h9;
  localparam logic [3:0] FN_TUTD = 4'ha;
  localparam logic [3:0] FN_DIRA = 4'hb;
  localparam logic [3:0] FN_AUTO = 4'hc;
  localparam logic [3:0] FN_TACB = 4'hd;
  localparam logic [3:0] FN_CATB = 4'he;
  localparam logic [3:0] FN_TAGB = 4'hf;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tpmi_bus_s;

  // bit 0 is compare 0, matching the SRC_ positions
  typedef struct packed {
    logic ovf;
    logic cap1;
    logic cap0;
    logic cmp1;
    logic cmp0;
  } tpmi_evt_s;

  typedef struct packed {
    logic useExt;
    logic presc;
    logic intRun;
    logic countUp;
    logic step;
    logic load0;
    logic cap0;
    logic cap1;
  } tpmi_core_s;

endpackage

/* src/tpmi_timer_pins.sv */
// input pin modes, output actions, chip event and interrupt vectoring of the timer
//
// Functional notes
// - A four-bit field picks one of sixteen input pin role combinations.
// - Trigger on A reloads from register 0, or captures into it.
// - Ext clock on B clocks prescaler; direction from software bit.
// - Trigger on A starts register 0 action; internal clock, software direction.
// - Gate on A enables B as prescaler clock; software direction.
// - Dual trigger: A acts on register 0, B on register 1.
// - Edge on A counts up, on B down; B wins.
// - A level sets direction, B clocks prescaler.
// - Edge on A selects up, on B down; B wins; internal clock.
// - A level sets direction, internal clock, software bit ignored.
// - B rise/fall while A low counts up/down; nothing while A high.
// - Trigger on A for register 0, B clocks prescaler.
// - Trigger on B captures into register 1, A clocks prescaler.
// - Trigger on A for register 0; counter runs while B low.
// - Each output: nop/set/reset/toggle per compare 0, compare 1, overflow.
// - Each output has a preset level loaded on a write to its control register, overriding same-cycle event actions.
// - Chip event from overflow or compare 0 when enabled.
// - Vector low bits: compare 110, capture 100, overflow 000.
// - Upper five vector bits come from the vector register.
// - Per-source mask bits plus global enable at mask bit 7.
// - Compare 0 or capture 0 while pending raises its overrun flag.
module tpmi_timer_pins
  import tpmi_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register port
  input wire tpmi_pkg::tpmi_bus_s bus,
  output logic [7:0] busRdata,
  // pins
  input wire logic timerInputA,
  input wire logic timerInputB,
  output logic timerOutputA,
  output logic timerOutputB,
  // counter core side
  input wire tpmi_pkg::tpmi_evt_s ev,
  output tpmi_pkg::tpmi_core_s coreCtl,
  output logic chipEvent,
  // interrupt
  output logic irqReq,
  output logic [7:0] irqVector
);

  typedef struct packed {
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic lvlA;
    logic lvlB;
    logic prevA;
    logic prevB;
    logic [7:0] icr;
    logic [7:0] timer_control_reg;
    logic [7:0] oac;
    logic [7:0] obc;
    logic [7:0] ivr;
    logic [7:0] msk;
    logic [4:0] pend;
    logic [1:0] ovr;
    logic dir;
    logic outA;
    logic outB;
    tpmi_core_s core;
    logic chipEv;
    logic irq;
    logic [7:0] vec;
    logic [7:0] rdata;
  } tpmi_state_s;

  tpmi_state_s st_r;
  tpmi_state_s st_nxt;

  function automatic logic edgeHit(input logic [1:0] sel, input logic rise, input logic fall);
    edgeHit = (sel[0] & rise) | (sel[1] & fall);
  endfunction

  function automatic logic applyAct(input logic cur, input logic [1:0] act);
    unique case (act)
      ACT_SET: applyAct = 1'b1;
      ACT_RST: applyAct = 1'b0;
      ACT_TGL: applyAct = ~cur;
      default: applyAct = cur;
    endcase
  endfunction

  // overflow first, then compare 0, then compare 1 when events coincide
  function automatic logic outStep(input logic cur, input logic [7:0] ctl, input tpmi_evt_s e);
    logic o;
    o = cur;
    if (e.ovf) o = applyAct(o, ctl[OC_OVF_LSB +: 2]);
    if (e.cmp0) o = applyAct(o, ctl[OC_CMP0_LSB +: 2]);
    if (e.cmp1) o = applyAct(o, ctl[OC_CMP1_LSB +: 2]);
    outStep = o;
  endfunction

  logic riseA, fallA, riseB, fallB, trgA, trgB, actA, rm0;
  logic [3:0] fn;
  logic [4:0] act;
  logic [4:0] evBits;
  logic [4:0] clr;
  tpmi_core_s c;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.syncA = {st_r.syncA[1:0], timerInputA};
    st_nxt.syncB = {st_r.syncB[1:0], timerInputB};
    if (st_r.syncA[2] == st_r.syncA[1]) st_nxt.lvlA = st_r.syncA[2];
    if (st_r.syncB[2] == st_r.syncB[1]) st_nxt.lvlB = st_r.syncB[2];
    st_nxt.prevA = st_r.lvlA;
    st_nxt.prevB = st_r.lvlB;
    riseA = st_r.lvlA & ~st_r.prevA;
    fallA = ~st_r.lvlA & st_r.prevA;
    riseB = st_r.lvlB & ~st_r.prevB;
    fallB = ~st_r.lvlB & st_r.prevB;
    trgA = edgeHit(st_r.icr[ICR_EA_LSB +: 2], riseA, fallA);
    trgB = edgeHit(st_r.icr[ICR_EB_LSB +: 2], riseB, fallB);
    fn = st_r.icr[ICR_FN_LSB +: 4];
    rm0 = st_r.timer_control_reg[TCR_RM0];
    actA = 1'b0;
    c = '0;
    c.intRun = 1'b1;
    st_nxt.dir = st_r.timer_control_reg[TCR_DIR];
    unique case (fn)
      FN_NONE: begin
      end
      FN_TRGB: begin
        c.cap1 = trgB;
      end
      // gate runs the counter while low
      FN_GATA: begin
        c.intRun = ~st_r.lvlA;
      end
      FN_GATRB: begin
        c.intRun = ~st_r.lvlA;
        c.cap1 = trgB;
      end
      FN_CLKB: begin
        c.useExt = 1'b1;
        c.intRun = 1'b0;
        c.presc = trgB;
      end
      FN_TRGA: begin
        actA = trgA;
      end
      // B clock gated by A low
      FN_GACB: begin
        c.useExt = 1'b1;
        c.intRun = 1'b0;
        c.presc = trgB & ~st_r.lvlA;
      end
      FN_TRAB: begin
        actA = trgA;
        c.cap1 = trgB;
      end
      // clock up on A, down on B
      FN_UPDN: begin
        c.useExt = 1'b1;
        c.intRun = 1'b0;
        c.step = trgA | trgB;
        if (trgB) st_nxt.dir = 1'b0;
        else if (trgA) st_nxt.dir = 1'b1;
        else st_nxt.dir = st_r.dir;
      end
      // direction from A, clock from B
      FN_DACB: begin
        c.useExt = 1'b1;
        c.intRun = 1'b0;
        c.presc = trgB;
        st_nxt.dir = st_r.lvlA;
      end
      FN_TUTD: begin
        if (trgB) st_nxt.dir = 1'b0;
        else if (trgA) st_nxt.dir = 1'b1;
        else st_nxt.dir = st_r.dir;
      end
      FN_DIRA: begin
        st_nxt.dir = st_r.lvlA;
      end
      FN_AUTO: begin
        c.useExt = 1'b1;
        c.intRun = 1'b0;
        c.step = ~st_r.lvlA & (riseB | fallB);
        st_nxt.dir = (~st_r.lvlA & (riseB | fallB)) ? riseB : st_r.dir;
      end
      FN_TACB: begin
        actA = trgA;
        c.useExt = 1'b1;
        c.intRun = 1'b0;
        c.presc = trgB;
      end
      FN_CATB: begin
        c.useExt = 1'b1;
        c.intRun = 1'b0;
        c.presc = trgA;
        c.cap1 = trgB;
      end
      FN_TAGB: begin
        actA = trgA;
        c.intRun = ~st_r.lvlB;
      end
    endcase
    // reload or capture on register 0
    c.load0 = actA & ~rm0;
    c.cap0 = actA & rm0;
    c.countUp = st_nxt.dir;
    st_nxt.core = c;

    st_nxt.outA = outStep(st_r.outA, st_r.oac, ev);
    st_nxt.outB = outStep(st_r.outB, st_r.obc, ev);
    st_nxt.chipEv = (ev.ovf & st_r.oac[OC_EV]) | (ev.cmp0 & st_r.obc[OC_EV]);

    // register writes
    clr = '0;
    if (bus.wr) begin
      unique case (bus.addr)
        ADR_ICR: st_nxt.icr = bus.wdata;
        ADR_TCR: st_nxt.timer_control_reg = bus.wdata;
        ADR_OAC: begin
          st_nxt.oac = bus.wdata;
          st_nxt.outA = bus.wdata[OC_PRE];
        end
        ADR_OBC: begin
          st_nxt.obc = bus.wdata;
          st_nxt.outB = bus.wdata[OC_PRE];
        end
        ADR_IVR: st_nxt.ivr = bus.wdata;
        ADR_MSK: st_nxt.msk = bus.wdata;
        ADR_FLG: clr = bus.wdata[4:0];
        default: begin
        end
      endcase
    end

    // pending flags: write one clears, a new event wins over the clear
    evBits = ev;
    st_nxt.pend = (st_r.pend & ~clr) | evBits;
    // overrun on compare 0 and capture 0
    st_nxt.ovr[0] = (st_r.ovr[0] & ~(bus.wr & (bus.addr == ADR_FLG) & bus.wdata[FLG_OVR0]))
      | (ev.cmp0 & st_r.pend[SRC_CMP0]);
    st_nxt.ovr[1] = (st_r.ovr[1] & ~(bus.wr & (bus.addr == ADR_FLG) & bus.wdata[FLG_OVR1]))
      | (ev.cap0 & st_r.pend[SRC_CAP0]);

    act = st_r.pend & st_r.msk[4:0];
    st_nxt.irq = st_r.msk[MSK_GLB] & (|act);
    st_nxt.vec[7:IVR_LSB] = st_r.ivr[7:IVR_LSB];
    if (act[SRC_OVF]) st_nxt.vec[2:0] = VEC_OVF;
    else if (act[SRC_CAP0] | act[SRC_CAP1]) st_nxt.vec[2:0] = VEC_CAP;
    else st_nxt.vec[2:0] = VEC_CMP;

    // read data stands for one cycle only; unmapped reads give zero
    st_nxt.rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        ADR_ICR: st_nxt.rdata = st_r.icr;
        ADR_TCR: st_nxt.rdata = st_r.timer_control_reg;
        ADR_OAC: st_nxt.rdata = st_r.oac;
        ADR_OBC: st_nxt.rdata = st_r.obc;
        ADR_IVR: st_nxt.rdata = st_r.ivr;
        ADR_MSK: st_nxt.rdata = st_r.msk;
        ADR_FLG: st_nxt.rdata = {1'b0, st_r.ovr, st_r.pend};
        ADR_STA: st_nxt.rdata = {3'h0, st_r.dir, st_r.outB, st_r.outA, st_r.lvlB, st_r.lvlA};
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.icr <= RST_ICR;
      st_r.timer_control_reg <= RST_TCR;
      st_r.oac <= RST_OC;
      st_r.obc <= RST_OC;
      st_r.ivr <= RST_IVR;
      st_r.msk <= RST_MSK;
      st_r.core.intRun <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busRdata = st_r.rdata;
  assign timerOutputA = st_r.outA;
  assign timerOutputB = st_r.outB;
  assign coreCtl = st_r.core;
  assign chipEvent = st_r.chipEv;
  assign irqReq = st_r.irq;
  assign irqVector = st_r.vec;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_riseHeld;
    $rose(timerInputA) ##1 timerInputA [*3];
  endsequence
  property p_syncA;
    s_riseHeld |=> st_r.lvlA;
  endproperty
  a_syncA: assert property (p_syncA) else $error("input A level not taken after settling");

  property p_trgA;
    (fn == FN_TRGA && trgA && rm0) |=> (coreCtl.cap0 && !coreCtl.load0);
  endproperty
  a_trgA: assert property (p_trgA) else $error("trigger A did not capture");

  property p_clkB;
    (fn == FN_CLKB && trgB) |=> (coreCtl.presc && coreCtl.useExt);
  endproperty
  a_clkB: assert property (p_clkB) else $error("B edge did not clock prescaler");

  property p_updn;
    (fn == FN_UPDN && trgB) |=> (coreCtl.step && !coreCtl.countUp);
  endproperty
  a_updn: assert property (p_updn) else $error("B edge did not count down");

  property p_dira;
    (fn == FN_DIRA && st_r.lvlA && !bus.wr) |=> coreCtl.countUp;
  endproperty
  a_dira: assert property (p_dira) else $error("A high did not select up");

  property p_auto;
    (fn == FN_AUTO && st_r.lvlA) |=> !coreCtl.step;
  endproperty
  a_auto: assert property (p_auto) else $error("step while A high");

  property p_preset;
    (bus.wr && bus.addr == ADR_OAC) |=> (timerOutputA == $past(bus.wdata[OC_PRE]));
  endproperty
  a_preset: assert property (p_preset) else $error("output A preset not applied");

  property p_chip;
    (ev.ovf && st_r.oac[OC_EV]) |=> chipEvent;
  endproperty
  a_chip: assert property (p_chip) else $error("chip event missing");

  property p_ovr;
    (ev.cmp0 && st_r.pend[SRC_CMP0]) |=> st_r.ovr[0];
  endproperty
  a_ovr: assert property (p_ovr) else $error("compare 0 overrun not flagged");

  property p_vecOvf;
    (st_r.pend[SRC_OVF] && st_r.msk[SRC_OVF] && st_r.msk[MSK_GLB])
      |=> (irqReq && irqVector[2:0] == 3'h0);
  endproperty
  a_vecOvf: assert property (p_vecOvf) else $error("overflow vector wrong");

  property p_glb;
    !st_r.msk[MSK_GLB] |=> !irqReq;
  endproperty
  a_glb: assert property (p_glb) else $error("irq while globally masked");

endmodule

/* test/tpmi_pin_model.sv */
// far-side model that drives the two timer input pins
module tpmi_pin_model (
  // clock
  input wire logic sys_clk,
  // pins
  output logic timerInputA,
  output logic timerInputB
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    timerInputA = 1'b0;
    timerInputB = 1'b0;
  end

  // levels move just after an edge; callers hold each level 3+ cycles
  task automatic drive(input logic a, input logic b);
    @(posedge sys_clk);
    timerInputA <= a;
    timerInputB <= b;
  endtask
endmodule

/* test/tb.sv */
// self-checking bench for the timer pin, output and interrupt block
module tb import tpmi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // {oac, obc, msk, ev, {outA, outB, chip, irq}, vector low bits}
  typedef struct packed {
    logic [7:0] oac, obc, msk;
    logic [4:0] ev;
    logic [3:0] out;
    logic [2:0] vec;
  } tpmi_row_s;

  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  tpmi_bus_s bus = '0;
  tpmi_evt_s ev = '0;
  tpmi_core_s coreCtl;
  logic [7:0] busRdata, irqVector;
  logic timerInputA, timerInputB, timerOutputA, timerOutputB, chipEvent, irqReq;
  int failures = 0;
  int nTests = 0;
  tpmi_row_s rows [9] = '{
    '{8'h40, 8'h00, 8'h80, 5'h01, 4'h8, 3'h0},
    '{8'h01, 8'h42, 8'h81, 5'h01, 4'h9, 3'h6},
    '{8'h0c, 8'h44, 8'h82, 5'h02, 4'hd, 3'h6},
    '{8'hf0, 8'h60, 8'h90, 5'h10, 4'h3, 3'h0},
    '{8'h00, 8'h80, 8'h84, 5'h05, 4'h3, 3'h4},
    '{8'h80, 8'h00, 8'h88, 5'h09, 4'h1, 3'h4},
    '{8'h12, 8'h80, 8'h9f, 5'h11, 4'h3, 3'h0},
    '{8'h00, 8'h00, 8'h1f, 5'h10, 4'h0, 3'h0},
    '{8'h4c, 8'h30, 8'h82, 5'h12, 4'h5, 3'h6}};

  always #10 sys_clk = ~sys_clk;

  tpmi_timer_pins DUT (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .busRdata(busRdata),
    .timerInputA(timerInputA), .timerInputB(timerInputB), .timerOutputA(timerOutputA),
    .timerOutputB(timerOutputB), .ev(ev), .coreCtl(coreCtl), .chipEvent(chipEvent),
    .irqReq(irqReq), .irqVector(irqVector));

  tpmi_pin_model PINS (.sys_clk(sys_clk), .timerInputA(timerInputA),
    .timerInputB(timerInputB));

////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    nTests++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1 chk(n, busRdata, e);
  endtask

  task automatic pulse(input logic [4:0] e);
    @(posedge sys_clk);
    ev <= e;
    @(posedge sys_clk);
    ev <= '0;
    #1;
  endtask

  // pins = {a0, b0, a1, b1}: settle at a0/b0, then move to a1/b1 and watch
  task automatic mode(input logic [7:0] icr, timer_control_reg, input logic [3:0] pins,
                      input logic [7:0] p, l, m);
    logic [7:0] acc;
    int first;
    acc = '0;
    first = 0;
    wr(ADR_ICR, icr);
    wr(ADR_TCR, timer_control_reg);
    PINS.drive(pins[3], pins[2]);
    repeat (10) @(posedge sys_clk);
    PINS.drive(pins[1], pins[0]);
    for (int i = 1; i < 10; i++) begin
      @(posedge sys_clk);
      #1;
      if (first == 0 && (coreCtl & 8'h4f) != 8'h00) first = i;
      acc |= coreCtl & 8'h4f;
    end
    chk("pulses", acc, p);
    chk("levels", coreCtl & m, l);
    // pin change at cycle 0: level at 4, edge seen at 4, registered pulse at 5
    if (p != 8'h00) chk("delay", 8'(first), 8'h05);
  endtask

////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (9) @(posedge sys_clk);
    #1 chk("rstOut", {4'h0, timerOutputA, timerOutputB, chipEvent, irqReq}, 8'h00);
    chk("rstCore", coreCtl, 8'h20);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 10; a++) rd(4'(a), 8'h00, "rstReg");
    wr(ADR_IVR, 8'ha8);
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00, "unmapped");
    rd(ADR_IVR, 8'ha8, "vecReg");
    // a nonzero read must fall back to zero one cycle later
    @(posedge sys_clk);
    #1 chk("rdStand", busRdata, 8'h00);
    foreach (rows[i]) begin
      wr(ADR_FLG, 8'h7f);
      wr(ADR_MSK, rows[i].msk);
      wr(ADR_OAC, rows[i].oac);
      wr(ADR_OBC, rows[i].obc);
      pulse(rows[i].ev);
      chk("outs", {5'h0, timerOutputA, timerOutputB, chipEvent}, {5'h0, rows[i].out[3:1]});
      @(posedge sys_clk);
      #1 chk("irq", {7'h0, irqReq}, {7'h0, rows[i].out[0]});
      if (rows[i].out[0]) chk("vector", irqVector, {5'h15, rows[i].vec});
      rd(ADR_FLG, {3'h0, rows[i].ev}, "pending");
    end
    wr(ADR_FLG, 8'h7f);
    pulse(5'h07);
    pulse(5'h07);
    rd(ADR_FLG, 8'h67, "overrun");
    wr(ADR_FLG, 8'h7f);
    rd(ADR_FLG, 8'h00, "flagClear");
    mode(8'h54, 8'h01, 4'b0001, 8'h40, 8'h90, 8'h90);
    mode(8'h54, 8'h00, 4'b0001, 8'h40, 8'h80, 8'h90);
    mode(8'h55, 8'h02, 4'b0010, 8'h02, 8'h00, 8'h90);
    mode(8'h55, 8'h01, 4'b0010, 8'h04, 8'h10, 8'h90);
    mode(8'h65, 8'h00, 4'b0010, 8'h00, 8'h00, 8'h00);
    mode(8'h75, 8'h00, 4'b1000, 8'h04, 8'h00, 8'h00);
    mode(8'h56, 8'h00, 4'b0001, 8'h40, 8'h80, 8'h90);
    mode(8'h56, 8'h00, 4'b1011, 8'h00, 8'h00, 8'h00);
    mode(8'h52, 8'h00, 4'b0010, 8'h00, 8'h00, 8'h20);
    mode(8'h52, 8'h00, 4'b1000, 8'h00, 8'h20, 8'h20);
    mode(8'h57, 8'h02, 4'b0010, 8'h02, 8'h00, 8'h00);
    mode(8'h57, 8'h02, 4'b0001, 8'h01, 8'h00, 8'h00);
    mode(8'h58, 8'h00, 4'b0010, 8'h08, 8'h10, 8'h10);
    mode(8'h58, 8'h01, 4'b0001, 8'h08, 8'h00, 8'h10);
    mode(8'h58, 8'h00, 4'b0011, 8'h08, 8'h00, 8'h10);
    mode(8'h59, 8'h00, 4'b1011, 8'h40, 8'h90, 8'h90);
    mode(8'h59, 8'h01, 4'b0001, 8'h40, 8'h80, 8'h90);
    mode(8'h5a, 8'h00, 4'b0010, 8'h00, 8'h10, 8'h10);
    mode(8'h5a, 8'h01, 4'b0011, 8'h00, 8'h00, 8'h10);
    mode(8'h5b, 8'h00, 4'b0010, 8'h00, 8'h10, 8'h10);
    mode(8'h5b, 8'h01, 4'b1000, 8'h00, 8'h00, 8'h10);
    mode(8'h5c, 8'h00, 4'b0001, 8'h08, 8'h10, 8'h10);
    mode(8'h5c, 8'h01, 4'b0100, 8'h08, 8'h00, 8'h10);
    mode(8'h5c, 8'h00, 4'b1011, 8'h00, 8'h00, 8'h00);
    mode(8'h5d, 8'h02, 4'b0010, 8'h02, 8'h80, 8'h80);
    mode(8'h5d, 8'h00, 4'b0001, 8'h40, 8'h80, 8'h80);
    mode(8'h5e, 8'h00, 4'b0001, 8'h01, 8'h00, 8'h00);
    mode(8'h5e, 8'h00, 4'b0010, 8'h40, 8'h80, 8'h80);
    mode(8'h5f, 8'h00, 4'b0010, 8'h04, 8'h20, 8'h20);
    mode(8'h5f, 8'h00, 4'b0001, 8'h00, 8'h00, 8'h20);
    // mid-run reset drops the outputs at once and restores register values
    wr(ADR_OAC, 8'h40);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    #1 chk("rstMidOut", {7'h0, timerOutputA}, 8'h00);
    chk("rstMidCore", coreCtl, 8'h20);
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(ADR_OAC, 8'h00, "rstMidReg");
    tally_and_finish();
  end

  // the full sequence needs well under 2000 cycles
  initial begin
    #200_000;
    failures++;
    tally_and_finish();
  end
endmodule
